// File: peru_defs.svh
// Purpose: shared constants of the programming-executive response unit
// Assumes: included by its bare name; definitions only
// Notes:   opcodes, codes, field positions and lengths of response headers
`ifndef PERU_DEFS_SVH
`define PERU_DEFS_SVH

// ----------------------------------------------------------------
// command opcodes seen by the response unit
// ----------------------------------------------------------------
`define PERU_OP_PROGRAM_MEMORY_READ_CMD      4'h2
`define PERU_OP_BLANK      4'ha
`define PERU_OP_VERSION    4'hb
`define PERU_LEN_VERSION   12'h001
`define PERU_LEN_BLANK     12'h003

// ----------------------------------------------------------------
// response status opcodes and query/error bytes
// ----------------------------------------------------------------
`define PERU_ST_PASS       4'h1
`define PERU_ST_FAIL       4'h2
`define PERU_ST_UNKNOWN    4'h3
`define PERU_QE_BLANK      8'hf0
`define PERU_QE_NOT_BLANK  8'h0f
`define PERU_QE_NO_ERROR   8'h00
`define PERU_QE_VERIFY     8'h01
`define PERU_QE_OTHER      8'h02

// ----------------------------------------------------------------
// header layout and lengths
// ----------------------------------------------------------------
`define PERU_HDR_ST_MSB    15
`define PERU_HDR_ST_LSB    12
`define PERU_HDR_CMD_MSB   11
`define PERU_HDR_CMD_LSB   8
`define PERU_HDR_QE_MSB    7
`define PERU_HDR_QE_LSB    0
`define PERU_LEN_HEADER    16'h0002

// ----------------------------------------------------------------
// nvm control register and serial command codes
// ----------------------------------------------------------------
`define PERU_NVM_WIP_BIT   15
`define PERU_NVM_RESET     16'h0000
`define PERU_NVM_ERASE     16'h4042
`define PERU_NVM_ROW_PROG  16'h4001
`define PERU_TBL_PAGE_EXEC 8'h80
`define PERU_SER_EXECUTE   4'h0
`define PERU_SER_VISI_OUT  4'h1

`endif

// File: peru_pkg.sv
// Purpose: types of the programming-executive response unit
// Assumes: nothing else is needed to compile it
// Notes:   used as peru_pkg::name, never imported
package peru_pkg;

  // ----------------------------------------------------------------
  // response sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PERU_IDLE,
    PERU_HDR0,
    PERU_HDR1,
    PERU_DATA
  } peru_state_t;

endpackage

// File: peru_prog_model.sv
// Purpose: programmer-side consumer of response words
// Assumes: ready changes on falling edges, like the bench stimulus
// Notes:   slow mode raises ready on a fixed pattern, one cycle in eight
`timescale 1ns/1ns

// ----------------------------------------------------------------
// response consumer
// ----------------------------------------------------------------
module peru_prog_model
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        resp_valid,
  input  wire logic [15:0] resp_word,
  output logic             resp_ready,
  output logic             took_q,
  output logic      [15:0] took_word_q
);
  logic [2:0] stall_q;

  // stall pattern; a slow programmer makes the unit hold each word
  always @(negedge clk_sys)
  begin
    if (reset)
    begin
      stall_q    <= 3'h0;
      resp_ready <= 1'b0;
    end
    else
    begin
      stall_q    <= stall_q + 3'h1;
      resp_ready <= !slow || (stall_q == 3'h5);
    end
  end

  // a word is consumed at the rising edge where valid and ready meet
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      took_q <= 1'b0;
    else
      took_q <= resp_valid && resp_ready;
  end

  // captured word, only meaningful while took_q is high
  always_ff @(posedge clk_sys)
  begin
    took_word_q <= resp_word;
  end
endmodule

// File: peru_response_unit.sv
// Purpose: response side of the programming executive with nvm control helpers
// Assumes: all inputs synchronous to clk_sys; packed read data arrives
//          already formatted on the data stream
// Notes:   one command in flight; response words leave on a valid/ready port
//
// Function
// - version query is opcode Bh with length field 1h.
// - version byte holds main version high nibble, revision low nibble.
// - version response is 1B plus version byte, then length 0002h.
// - exactly one response per received command, carrying result or error.
// - status is 1h pass, 2h fail, 3h unknown command.
// - header word status 15:12, command 11:8, query/error 7:0, then length.
// - command field echoes the opcode just processed.
// - one command at a time; next waits for the response.
// - queries always report pass and return query data in the byte.
// - blank check byte is F0h when blank, 0Fh otherwise.
// - error byte 0h ok, 1h row/id verify fail, 2h other.
// - length counts header words; all responses two words except memory read.
// - memory read length is three times half N rounded up plus two.
// - device clears bit 15 when the cycle ends; programmer polls it. Here a write in the same cycle wins and loads bit 15 from nvm_wr_data.
// - serial code 0000 executes an instruction, 0001 shifts out visibility data.
// - blank check is opcode Ah length 3h; header 1AF0h or 1A0Fh.
`timescale 1ns/1ns
`include "peru_defs.svh"

// ----------------------------------------------------------------
// fifo for packed read data
// ----------------------------------------------------------------
module peru_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready_q,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             push;
  logic             pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("peru_fifo: DEPTH must be a power of two of at least 2");
  end

  // handshakes on both sides; ready is registered so the top sees a flop
  assign push     = in_valid && in_ready_q;
  assign pop      = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem[rd_ptr_q];

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
    begin
      count_d = count_q + 1'b1;
    end
    else if (pop && !push)
    begin
      count_d = count_q - 1'b1;
    end
  end

  // storage has no reset; only pointers, count and ready carry control state
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers, occupancy and the registered ready
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_q   <= '0;
      rd_ptr_q   <= '0;
      count_q    <= '0;
      in_ready_q <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q    <= count_d;
      in_ready_q <= (count_d != DEPTH[AW:0]);
    end
  end
endmodule

// ----------------------------------------------------------------
// response unit top
// ----------------------------------------------------------------
module peru_response_unit
#(
  parameter logic [7:0] VERSION = 8'h10, // main.revision of the stored executive
  parameter int         CNT_W   = 12,    // width of the read word count
  parameter int         DEPTH   = 8
)
(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready_q,
  input  wire logic [3:0]       cmd_opcode,
  input  wire logic [11:0]      cmd_length,
  input  wire logic             cmd_known,
  input  wire logic             cmd_failed,
  input  wire logic             cmd_verify_fail,
  input  wire logic             cmd_is_blank,
  input  wire logic [CNT_W-1:0] cmd_read_count,
  input  wire logic             rd_data_valid,
  output logic                  rd_data_ready_q,
  input  wire logic [15:0]      rd_data,
  output logic                  resp_valid_q,
  input  wire logic             resp_ready,
  output logic      [15:0]      resp_word_q,
  input  wire logic             nvm_wr_en,
  input  wire logic [15:0]      nvm_wr_data,
  input  wire logic             nvm_cycle_done,
  output logic      [15:0]      nvm_control_reg_q,
  input  wire logic             visi_wr_en,
  input  wire logic [15:0]      visi_wr_data,
  input  wire logic             ser_cmd_valid,
  input  wire logic [3:0]       ser_cmd_code,
  input  wire logic [23:0]      ser_instr,
  output logic                  exec_valid_q,
  output logic      [23:0]      exec_instr_q,
  output logic                  visi_out_valid_q,
  output logic      [15:0]      visi_out_q
);
  peru_pkg::peru_state_t state_q;
  logic [15:0]           hdr0_q;
  logic [15:0]           len_q;
  logic [15:0]           rem_q;
  logic [15:0]           visi_q;
  logic                  accept;
  logic                  slot_free;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic [15:0]           fifo_data;

  if (CNT_W < 1 || CNT_W > 14)
  begin : g_bad_count
    $error("peru_response_unit: CNT_W must lie in 1..14 to fit the length word");
  end

  // ----------------------------------------------------------------
  // header construction
  // ----------------------------------------------------------------
  // first header word from the processed command and its outcome
  function automatic logic [15:0] make_hdr0(input logic [3:0] op,
                                            input logic       known,
                                            input logic       failed,
                                            input logic       vfail,
                                            input logic       blank);
    logic [3:0] st;
    logic [7:0] qe;
    st = `PERU_ST_PASS;
    qe = `PERU_QE_NO_ERROR;
    if (!known)
    begin
      st = `PERU_ST_UNKNOWN;
    end
    else if (op == `PERU_OP_VERSION)
    begin
      qe = VERSION;
    end
    else if (op == `PERU_OP_BLANK)
    begin
      qe = blank ? `PERU_QE_BLANK : `PERU_QE_NOT_BLANK;
    end
    else if (failed)
    begin
      st = `PERU_ST_FAIL;
      qe = vfail ? `PERU_QE_VERIFY : `PERU_QE_OTHER;
    end
    return {st, op, qe};
  endfunction

  // length word: packed read carries three words per pair of instructions
  function automatic logic [15:0] make_len(input logic [3:0]       op,
                                           input logic             known,
                                           input logic [CNT_W-1:0] n);
    logic [15:0] half;
    half = 16'(({1'b0, n} + 1'b1) >> 1);
    if (known && op == `PERU_OP_PROGRAM_MEMORY_READ_CMD)
    begin
      return 16'(half * 16'd3) + `PERU_LEN_HEADER;
    end
    return `PERU_LEN_HEADER;
  endfunction

  assign accept    = cmd_valid && cmd_ready_q;
  assign slot_free = !resp_valid_q || resp_ready;
  assign fifo_pop  = (state_q == peru_pkg::PERU_DATA) && slot_free && (rem_q != 16'h0000);

  peru_fifo
  #(
    .WIDTH (16),
    .DEPTH (DEPTH)
  )
  u_fifo
  (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .in_valid   (rd_data_valid),
    .in_ready_q (rd_data_ready_q),
    .in_data    (rd_data),
    .out_valid  (fifo_valid),
    .out_ready  (fifo_pop),
    .out_data   (fifo_data)
  );

  // ----------------------------------------------------------------
  // response sequencer
  // ----------------------------------------------------------------
  // command intake closes until the last response word is loaded
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_q      <= peru_pkg::PERU_IDLE;
      cmd_ready_q  <= 1'b0;
      hdr0_q       <= 16'h0000;
      len_q        <= 16'h0000;
      rem_q        <= 16'h0000;
      resp_valid_q <= 1'b0;
      resp_word_q  <= 16'h0000;
    end
    else
    begin
      if (resp_valid_q && resp_ready)
      begin
        resp_valid_q <= 1'b0;
      end
      case (state_q)
        peru_pkg::PERU_IDLE:
        begin
          cmd_ready_q <= 1'b1;
          if (accept)
          begin
            cmd_ready_q <= 1'b0;
            hdr0_q      <= make_hdr0(cmd_opcode, cmd_known, cmd_failed,
                                     cmd_verify_fail, cmd_is_blank);
            len_q       <= make_len(cmd_opcode, cmd_known, cmd_read_count);
            state_q     <= peru_pkg::PERU_HDR0;
          end
        end
        peru_pkg::PERU_HDR0:
        begin
          if (slot_free)
          begin
            resp_valid_q <= 1'b1;
            resp_word_q  <= hdr0_q;
            state_q      <= peru_pkg::PERU_HDR1;
          end
        end
        peru_pkg::PERU_HDR1:
        begin
          if (slot_free)
          begin
            resp_valid_q <= 1'b1;
            resp_word_q  <= len_q;
            rem_q        <= len_q - `PERU_LEN_HEADER;
            if (len_q == `PERU_LEN_HEADER)
            begin
              state_q     <= peru_pkg::PERU_IDLE;
              cmd_ready_q <= 1'b1;
            end
            else
            begin
              state_q <= peru_pkg::PERU_DATA;
            end
          end
        end
        peru_pkg::PERU_DATA:
        begin
          // stalls while the fifo is empty; the source is back-pressured only once the fifo is full, when its ready drops
          if (slot_free && fifo_valid)
          begin
            resp_valid_q <= 1'b1;
            resp_word_q  <= fifo_data;
            rem_q        <= rem_q - 16'h0001;
            if (rem_q == 16'h0001)
            begin
              state_q     <= peru_pkg::PERU_IDLE;
              cmd_ready_q <= 1'b1;
            end
          end
        end
        default:
        begin
          state_q <= peru_pkg::PERU_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // nvm control and visibility registers
  // ----------------------------------------------------------------
  // a write in the same cycle as completion wins, so a fresh start is not lost
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      nvm_control_reg_q <= `PERU_NVM_RESET;
    end
    else if (nvm_wr_en)
    begin
      nvm_control_reg_q <= nvm_wr_data;
    end
    else if (nvm_cycle_done)
    begin
      nvm_control_reg_q[`PERU_NVM_WIP_BIT] <= 1'b0;
    end
  end

  // visibility holding register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      visi_q <= 16'h0000;
    end
    else if (visi_wr_en)
    begin
      visi_q <= visi_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // serial command decode
  // ----------------------------------------------------------------
  // execute and shift-out requests become one-cycle strobes
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      exec_valid_q     <= 1'b0;
      exec_instr_q     <= 24'h000000;
      visi_out_valid_q <= 1'b0;
      visi_out_q       <= 16'h0000;
    end
    else
    begin
      exec_valid_q     <= ser_cmd_valid && (ser_cmd_code == `PERU_SER_EXECUTE);
      visi_out_valid_q <= ser_cmd_valid && (ser_cmd_code == `PERU_SER_VISI_OUT);
      if (ser_cmd_valid && ser_cmd_code == `PERU_SER_EXECUTE)
      begin
        exec_instr_q <= ser_instr;
      end
      if (ser_cmd_valid && ser_cmd_code == `PERU_SER_VISI_OUT)
      begin
        visi_out_q <= visi_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence s_accept_op(logic [3:0] op);
    accept && cmd_known && cmd_opcode == op;
  endsequence

  sequence s_hdr_load;
    state_q == peru_pkg::PERU_HDR0 && slot_free;
  endsequence

  a_version_hdr: assert property (s_accept_op(`PERU_OP_VERSION) |=>
    hdr0_q == {`PERU_ST_PASS, `PERU_OP_VERSION, VERSION} && len_q == `PERU_LEN_HEADER)
    else $error("version header wrong");
  a_blank_code: assert property (s_accept_op(`PERU_OP_BLANK) |=>
    hdr0_q[7:0] == ($past(cmd_is_blank) ? `PERU_QE_BLANK : `PERU_QE_NOT_BLANK)
    && hdr0_q[15:12] == `PERU_ST_PASS)
    else $error("blank check byte wrong");
  a_unknown_status: assert property (accept && !cmd_known |=>
    hdr0_q[15:12] == `PERU_ST_UNKNOWN)
    else $error("unknown command not flagged");
  a_error_code: assert property (accept && cmd_known && cmd_failed
    && cmd_opcode != `PERU_OP_BLANK && cmd_opcode != `PERU_OP_VERSION |=>
    hdr0_q[15:12] == `PERU_ST_FAIL
    && hdr0_q[7:0] == ($past(cmd_verify_fail) ? `PERU_QE_VERIFY : `PERU_QE_OTHER))
    else $error("error byte wrong");
  a_echo_cmd: assert property (accept |=> hdr0_q[11:8] == $past(cmd_opcode))
    else $error("echoed command wrong");
  a_one_at_time: assert property (accept |=> !cmd_ready_q ##1 !cmd_ready_q)
    else $error("command taken during response");
  a_hdr_out: assert property (s_hdr_load |=> resp_valid_q
    && resp_word_q == $past(hdr0_q) && state_q == peru_pkg::PERU_HDR1)
    else $error("header word not presented");
  a_len_short: assert property (accept && cmd_opcode != `PERU_OP_PROGRAM_MEMORY_READ_CMD |=>
    len_q == `PERU_LEN_HEADER)
    else $error("short response length wrong");
  a_wip_clear: assert property (nvm_cycle_done && !nvm_wr_en |=>
    !nvm_control_reg_q[`PERU_NVM_WIP_BIT])
    else $error("write-in-progress not cleared");
  a_exec_strobe: assert property (ser_cmd_valid && ser_cmd_code == `PERU_SER_EXECUTE |=>
    exec_valid_q && exec_instr_q == $past(ser_instr) ##1 !exec_valid_q || $past(ser_cmd_valid))
    else $error("execute strobe wrong");
endmodule

// File: peru_response_unit_tb.sv
// Purpose: self-checking bench of the response unit
// Assumes: inputs change on falling edges; queue model gives every word
// Notes:   nvm and serial helpers are driven the way a programmer would
`timescale 1ns/1ns
`include "peru_defs.svh"

module peru_response_unit_tb;
  localparam logic [7:0] VER = 8'h23;
  logic        clk_sys = 1'b0;
  logic        reset, cmd_valid, cmd_ready_q, cmd_known, cmd_failed;
  logic        cmd_verify_fail, cmd_is_blank, rd_data_valid, rd_data_ready_q;
  logic        resp_valid_q, resp_ready, nvm_wr_en, nvm_cycle_done, visi_wr_en;
  logic        ser_cmd_valid, exec_valid_q, visi_out_valid_q, slow, took_q;
  logic [3:0]  cmd_opcode, ser_cmd_code;
  logic [11:0] cmd_length, cmd_read_count;
  logic [15:0] rd_data, resp_word_q, nvm_wr_data, nvm_control_reg_q;
  logic [15:0] visi_wr_data, visi_out_q, took_word, nvm_m;
  logic [23:0] ser_instr, exec_instr_q;
  logic [15:0] exp_q[$];
  logic [15:0] dw[9];
  int          err_total, n_checks, n_got, n_exp, k, n;

  always #25 clk_sys = ~clk_sys;

  peru_response_unit #(.VERSION(VER), .CNT_W(12), .DEPTH(8)) uut
  (
    .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q),
    .cmd_opcode(cmd_opcode), .cmd_length(cmd_length), .cmd_known(cmd_known),
    .cmd_failed(cmd_failed), .cmd_verify_fail(cmd_verify_fail),
    .cmd_is_blank(cmd_is_blank), .cmd_read_count(cmd_read_count),
    .rd_data_valid(rd_data_valid), .rd_data_ready_q(rd_data_ready_q), .rd_data(rd_data),
    .resp_valid_q(resp_valid_q), .resp_ready(resp_ready), .resp_word_q(resp_word_q),
    .nvm_wr_en(nvm_wr_en), .nvm_wr_data(nvm_wr_data), .nvm_cycle_done(nvm_cycle_done),
    .nvm_control_reg_q(nvm_control_reg_q), .visi_wr_en(visi_wr_en),
    .visi_wr_data(visi_wr_data), .ser_cmd_valid(ser_cmd_valid),
    .ser_cmd_code(ser_cmd_code), .ser_instr(ser_instr), .exec_valid_q(exec_valid_q),
    .exec_instr_q(exec_instr_q), .visi_out_valid_q(visi_out_valid_q),
    .visi_out_q(visi_out_q)
  );

  peru_prog_model prog
  (
    .clk_sys(clk_sys), .reset(reset), .slow(slow), .resp_valid(resp_valid_q),
    .resp_word(resp_word_q), .resp_ready(resp_ready), .took_q(took_q),
    .took_word_q(took_word)
  );

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // bounded wait: 0 command ready, 1 fifo ready, 2 all words returned
  task automatic await(input int w);
    int i;
    for (i = 0; i < 400; i++)
    begin
      if (w == 0 && cmd_ready_q === 1'b1) return;
      if (w == 1 && rd_data_ready_q === 1'b1) return;
      if (w == 2 && exp_q.size() == 0) return;
      @(negedge clk_sys);
    end
    err_total++;
    $display("Error wait %0d expected done seen timeout", w);
    test_done();
  endtask

  // every consumed word is compared against the model queue in order
  always @(negedge clk_sys)
  begin
    if (took_q === 1'b1)
    begin
      n_got++;
      if (exp_q.size() == 0)
        chk("extra response word", took_word, 32'hffff_ffff);
      else
        chk("response word", took_word, exp_q.pop_front());
    end
  end

  // offers one command and queues the header the rules call for
  task automatic send_cmd(input logic [3:0] op, input logic kn, fl, vf, bl, input int cnt);
    int st, qe, len;
    st = !kn ? 3 : (op == 4'ha || op == 4'hb || !fl) ? 1 : 2;
    qe = !kn ? 0 : op == 4'hb ? VER : op == 4'ha ? (bl ? 'hf0 : 'h0f) : !fl ? 0 : vf ? 1 : 2;
    len = (kn && op == 4'h2) ? 3 * ((cnt + 1) / 2) + 2 : 2;
    exp_q.push_back(16'((st << 12) | (op << 8) | qe));
    exp_q.push_back(16'(len));
    n_exp += len;
    await(0);
    cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_length = op == 4'hb ? 12'h001 : op == 4'ha ? 12'h003 : 12'h004;
    {cmd_known, cmd_failed, cmd_verify_fail, cmd_is_blank} = {kn, fl, vf, bl};
    cmd_read_count = 12'(cnt);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    chk("cmd ready while busy", cmd_ready_q, 0);
  endtask

  // packed read words; valid stays high between words
  task automatic feed(input int a, input int b);
    int i;
    for (i = a; i < b; i++)
    begin
      await(1);
      rd_data_valid = 1'b1;
      rd_data = dw[i];
      @(negedge clk_sys);
    end
    rd_data_valid = 1'b0;
  endtask

  task automatic nvm_op(input logic wr, input logic [15:0] d, input logic done);
    {nvm_wr_en, nvm_wr_data, nvm_cycle_done} = {wr, d, done};
    if (wr)
      nvm_m = d;
    else if (done)
      nvm_m[15] = 1'b0;
    @(negedge clk_sys);
    {nvm_wr_en, nvm_cycle_done} = 2'h0;
    @(negedge clk_sys);
    chk("nvm control", nvm_control_reg_q, nvm_m);
  endtask

  // serial command; a pulse shows at the next edge and is gone at the one after, so look at both
  task automatic ser(input logic [3:0] code, input logic [23:0] ins, input int ve, vv);
    int i, ne, nv;
    {ser_cmd_valid, ser_cmd_code, ser_instr} = {1'b1, code, ins};
    ne = 0;
    nv = 0;
    for (i = 0; i < 2; i++)
    begin
      @(negedge clk_sys);
      ser_cmd_valid = 1'b0;
      if (exec_valid_q === 1'b1) ne++;
      if (visi_out_valid_q === 1'b1) nv++;
      if (exec_valid_q === 1'b1) chk("exec instr", exec_instr_q, ins);
      if (visi_out_valid_q === 1'b1) chk("visi out", visi_out_q, nvm_m);
    end
    chk("exec pulses", ne, ve);
    chk("visi pulses", nv, vv);
  endtask

  // programmer copies the control register to visibility and clocks it out
  task automatic poll;
    {visi_wr_en, visi_wr_data} = {1'b1, nvm_control_reg_q};
    @(negedge clk_sys);
    visi_wr_en = 1'b0;
    ser(`PERU_SER_VISI_OUT, 24'h0, 0, 1);
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_sys);
    err_total++;
    $display("Error run expected finish seen timeout");
    test_done();
  end

  initial
  begin
    reset = 1'b1;
    {slow, cmd_valid, cmd_opcode, cmd_length, cmd_known, cmd_failed} = '0;
    {cmd_verify_fail, cmd_is_blank, cmd_read_count, rd_data_valid, rd_data} = '0;
    {nvm_wr_en, nvm_wr_data, nvm_cycle_done, visi_wr_en, visi_wr_data} = '0;
    {ser_cmd_valid, ser_cmd_code, ser_instr, nvm_m} = '0;
    void'($urandom(47));
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    chk("cmd ready after reset", cmd_ready_q, 1);
    // queries report pass even when the core flags a failure
    send_cmd(4'hb, 1, 1, 0, 0, 0);
    send_cmd(4'ha, 1, 0, 0, 1, 0);
    send_cmd(4'ha, 1, 1, 0, 0, 0);
    await(2);
    $display("test queries done");
    // every other opcode, pass and both failure kinds, under a stalling programmer
    slow = 1'b1;
    for (k = 0; k < 16; k++)
      if (k != 2 && k != 10 && k != 11)
        send_cmd(4'(k), 1, k[0], k == 5, 0, 0);
    send_cmd(4'h4, 1, 1, 1, 0, 0);
    for (k = 0; k < 3; k++)
      send_cmd(4'($urandom), 0, 1, 0, 0, 0);
    await(2);
    $display("test status codes done");
    // reads of odd and even counts
    slow = 1'b0;
    for (n = 1; n < 5; n++)
    begin
      for (k = 0; k < 9; k++)
        dw[k] = 16'($urandom);
      feed(0, 3 * ((n + 1) / 2));
      send_cmd(4'h2, 1, 0, 0, 0, n);
      for (k = 0; k < 3 * ((n + 1) / 2); k++)
        exp_q.push_back(dw[k]);
      await(2);
    end
    // fill the fifo until it refuses, then drain it through a slow read
    slow = 1'b1;
    feed(0, 8);
    repeat (2) @(negedge clk_sys);
    chk("fifo full ready", rd_data_ready_q, 0);
    send_cmd(4'h2, 1, 0, 0, 0, 5);
    for (k = 0; k < 9; k++)
      exp_q.push_back(dw[k]);
    feed(8, 9);
    await(2);
    $display("test reads done");
    // erase both executive pages; page and pointer reach the core as instructions
    for (k = 0; k < 2; k++)
    begin
      nvm_op(1, `PERU_NVM_ERASE, 0);
      ser(`PERU_SER_EXECUTE, 24'(`PERU_TBL_PAGE_EXEC), 1, 0);
      ser(`PERU_SER_EXECUTE, 24'(k * 'h400), 1, 0);
      nvm_op(1, `PERU_NVM_ERASE | 16'h8000, 0);
      poll();
      nvm_op(0, 16'h0, 1);
      poll();
    end
    // row setup: control word, then a cleared write pointer
    nvm_op(1, `PERU_NVM_ROW_PROG, 1);
    ser(`PERU_SER_EXECUTE, 24'h000000, 1, 0);
    ser(`PERU_SER_EXECUTE, 24'($urandom), 1, 0);
    ser(4'h5, 24'($urandom), 0, 0);
    $display("test nvm and serial done");
    chk("words taken", n_got, n_exp);
    test_done();
  end
endmodule
